/* shared/snf_pkg.sv */
// constants, register layout and state codes of the serial flash setting registers
package snf_pkg;
  // link opcodes
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_GET = 8'h0F;
  localparam logic [7:0] OP_SET = 8'h1F;
  // setting addresses
  localparam logic [7:0] ADDR_CFG = 8'hB0;
  localparam logic [7:0] ADDR_STAT = 8'hC0;
  localparam logic [7:0] ADDR_DRV = 8'hD0;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h10;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] DRV_RST = 8'h20;
  // configuration field positions
  localparam int CFG_OTP_PROT = 7;
  localparam int CFG_OTP_EN = 6;
  localparam int CFG_FREEZE = 5;
  localparam int CFG_ECC_EN = 4;
  // status field positions
  localparam int ST_ECC_HI = 5;
  localparam int ST_ECC_LO = 4;
  localparam int ST_PFAIL = 3;
  localparam int ST_EFAIL = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  // drive field positions
  localparam int DRV_HI = 6;
  localparam int DRV_LO = 5;
  // ecc result codes
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_UNCORR = 2'h2;
  // last bit index of each frame byte
  localparam logic [4:0] BIT_OP_LAST = 5'h07;
  localparam logic [4:0] BIT_ADDR_LAST = 5'h0F;
  localparam logic [4:0] BIT_DATA_LAST = 5'h17;
  // widths of words crossing between domains
  localparam int CMD_W = 24;
  localparam int SNAP_W = 24;
  // operation state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PROG = 3'b001, ST_ERASE = 3'b010,
    ST_READ = 3'b011, ST_RESET = 3'b100, ST_BOOT = 3'b101
  } snf_state_t;
endpackage

/* shared/snf_lnk_if.sv */
// signals between the link engine and the register core
`timescale 1ns/1ps
interface snf_lnk_if;
  logic cmd_valid; // command word launched, link clock
  logic cmd_ready; // crossing free to take a command
  logic [snf_pkg::CMD_W-1:0] cmd_word; // opcode, address, data
  logic [snf_pkg::SNAP_W-1:0] snap_word; // register copy in link clock
  modport link (output cmd_valid, output cmd_word, input cmd_ready, input snap_word);
  modport core (input cmd_valid, input cmd_word, output cmd_ready, output snap_word);
endinterface

/* logic/snf_xfer.sv */
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module snf_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk_i,
  input wire logic src_rst_i,
  input wire logic src_valid_i,
  input wire logic [W-1:0] src_data_i,
  output logic src_ready_o,
  input wire logic dst_clk_i,
  input wire logic dst_rst_i,
  output logic dst_valid_o,
  output logic [W-1:0] dst_data_o
);
  logic req; // source toggle
  logic [W-1:0] hold; // word held stable while in flight
  logic ack_meta; // first stage, read only by ack_sync
  logic ack_sync;
  logic req_meta; // first stage, read only by req_sync
  logic req_sync;
  logic seen; // last toggle taken in destination
  logic next_req;
  logic [W-1:0] next_hold;

  // free when the returned toggle matches the launched one
  assign src_ready_o = (req == ack_sync);

  // launch a word only while free
  always_comb
  begin
    next_req = req;
    next_hold = hold;
    if (src_valid_i && src_ready_o)
    begin
      next_req = ~req;
      next_hold = src_data_i;
    end
  end

  // source side registers
  always_ff @(posedge src_clk_i)
  begin
    if (src_rst_i)
    begin
      req <= 1'h0;
      hold <= '0;
      ack_meta <= 1'h0;
      ack_sync <= 1'h0;
    end
    else
    begin
      req <= next_req;
      hold <= next_hold;
      ack_meta <= seen;
      ack_sync <= ack_meta;
    end
  end

  // destination side: capture on toggle change, return it as ack
  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
    begin
      req_meta <= 1'h0;
      req_sync <= 1'h0;
      seen <= 1'h0;
      dst_valid_o <= 1'h0;
      dst_data_o <= '0;
    end
    else
    begin
      req_meta <= req;
      req_sync <= req_meta;
      seen <= req_sync;
      dst_valid_o <= (req_sync != seen);
      if (req_sync != seen)
      begin
        dst_data_o <= hold;
      end
    end
  end
endmodule

/* logic/snf_spi_link.sv */
// serial link engine: frames opcodes, addresses and data bytes on the link clock
`timescale 1ns/1ps
module snf_spi_link (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  snf_lnk_if.link lnk
);
  logic [4:0] cnt; // bit index in the frame, data bits wrap from 23 back to 16
  logic [7:0] sh; // incoming shift register
  logic [7:0] op; // opcode of the frame
  logic [7:0] addr; // setting address of the frame
  logic [7:0] tx; // byte returned on a read
  logic [4:0] next_cnt;
  logic [7:0] next_sh;
  logic [7:0] next_op;
  logic [7:0] next_addr;
  logic [7:0] next_tx;
  logic fire; // complete command seen this edge

  // byte assembly and command decode
  always_comb
  begin
    next_sh = {sh[6:0], mosi_i};
    next_cnt = (cnt == snf_pkg::BIT_DATA_LAST) ? snf_pkg::BIT_ADDR_LAST + 5'h01 : cnt + 5'h01;
    next_op = op;
    next_addr = addr;
    next_tx = tx;
    fire = 1'h0;
    lnk.cmd_word = {op, addr, next_sh};
    if (cnt == snf_pkg::BIT_OP_LAST)
    begin
      // latch opcodes act on their own byte
      next_op = next_sh;
      lnk.cmd_word = {next_sh, 16'h0000};
      fire = (next_sh == snf_pkg::OP_WR_EN) || (next_sh == snf_pkg::OP_WR_DIS);
    end
    else if (cnt == snf_pkg::BIT_ADDR_LAST)
    begin
      next_addr = next_sh;
      // read reply picked from the register copy
      case (next_sh)
        snf_pkg::ADDR_CFG: next_tx = lnk.snap_word[23:16];
        snf_pkg::ADDR_STAT: next_tx = lnk.snap_word[15:8];
        snf_pkg::ADDR_DRV: next_tx = lnk.snap_word[7:0];
        default: next_tx = 8'h00;
      endcase
    end
    else if (cnt == snf_pkg::BIT_DATA_LAST)
    begin
      fire = (op == snf_pkg::OP_SET);
    end
    lnk.cmd_valid = fire && lnk.cmd_ready;
  end

  // frame state, cleared while select is high
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      cnt <= 5'h00;
      sh <= 8'h00;
      op <= 8'h00;
      addr <= 8'h00;
      tx <= 8'h00;
    end
    else
    begin
      cnt <= next_cnt;
      sh <= next_sh;
      op <= next_op;
      addr <= next_addr;
      tx <= next_tx;
    end
  end

  // reply bits change on the falling edge, msb first
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      miso_o <= 1'h0;
    end
    else
    begin
      miso_o <= tx[3'h7 - cnt[2:0]];
    end
  end

  // drive only in the data phase of a read
  assign miso_oe_o = !cs_n_i && (op == snf_pkg::OP_GET) && (cnt > snf_pkg::BIT_ADDR_LAST);

  a_get_reply: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    (cnt == snf_pkg::BIT_ADDR_LAST) && (op == snf_pkg::OP_GET) && (next_sh == snf_pkg::ADDR_STAT)
    |=> (tx == $past(lnk.snap_word[15:8])) && miso_oe_o)
    else $error("status reply byte not loaded");
endmodule

/* logic/snf_feature_regs.sv */
// setting registers of a serial flash: configuration, status and drive strength
`timescale 1ns/1ps
module snf_feature_regs (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic prog_req_i,
  input wire logic erase_req_i,
  input wire logic read_req_i,
  input wire logic reset_req_i,
  input wire logic target_locked_i,
  input wire logic target_invalid_i,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic [1:0] ecc_result_i,
  input wire logic guards_set_i,
  output logic prog_go_o,
  output logic erase_go_o,
  output logic read_go_o,
  output logic reset_go_o,
  output logic busy_o,
  output logic ecc_enable_o,
  output logic otp_access_o,
  output logic otp_writable_o,
  output logic otp_locked_o,
  output logic prot_frozen_o,
  output logic [2:0] drive_quarters_o
);
  snf_lnk_if lnk (); // link engine to core signals

  logic lnk_rst_meta; // first stage, read only by lnk_rst
  logic lnk_rst; // reset seen in the link clock
  logic cmd_valid; // command arrived, reference clock
  logic [snf_pkg::CMD_W-1:0] cmd_word; // command in reference clock
  logic [7:0] cmd_op;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_dat;

  // configuration fields
  logic otp_prot;
  logic otp_en;
  logic freeze;
  logic ecc_en;
  logic otp_locked; // sticky lock of the otp area
  // status fields
  logic [1:0] ecc_res;
  logic pfail;
  logic efail;
  logic write_enable_latch;
  snf_pkg::snf_state_t state;
  // drive field
  logic [1:0] drv;
  // next values
  logic next_otp_prot;
  logic next_otp_en;
  logic next_freeze;
  logic next_ecc_en;
  logic next_otp_locked;
  logic [1:0] next_ecc_res;
  logic next_pfail;
  logic next_efail;
  logic next_wel;
  snf_pkg::snf_state_t next_state;
  logic [1:0] next_drv;
  logic next_prog_go;
  logic next_erase_go;
  logic next_read_go;
  logic next_reset_go;
  // assembled register bytes
  logic [7:0] cfg_byte;
  logic [7:0] stat_byte;
  logic [7:0] drv_byte;

  // reset carried into the link clock for the crossings
  always_ff @(posedge sclk_i)
  begin
    lnk_rst_meta <= srst_i;
    lnk_rst <= lnk_rst_meta;
  end

  // link engine on the serial clock
  snf_spi_link u_link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .lnk(lnk.link)
  );

  // commands from link to core
  snf_xfer #(.W(snf_pkg::CMD_W)) u_cmd_xfer (
    .src_clk_i(sclk_i),
    .src_rst_i(lnk_rst),
    .src_valid_i(lnk.cmd_valid),
    .src_data_i(lnk.cmd_word),
    .src_ready_o(lnk.cmd_ready),
    .dst_clk_i(ref_clk_i),
    .dst_rst_i(srst_i),
    .dst_valid_o(cmd_valid),
    .dst_data_o(cmd_word)
  );

  // register copy from core to link, refreshed whenever free
  snf_xfer #(.W(snf_pkg::SNAP_W)) u_snap_xfer (
    .src_clk_i(ref_clk_i),
    .src_rst_i(srst_i),
    .src_valid_i(1'h1),
    .src_data_i({cfg_byte, stat_byte, drv_byte}),
    .src_ready_o(),
    .dst_clk_i(sclk_i),
    .dst_rst_i(lnk_rst),
    .dst_valid_o(),
    .dst_data_o(lnk.snap_word)
  );

  assign cmd_op = cmd_word[23:16];
  assign cmd_addr = cmd_word[15:8];
  assign cmd_dat = cmd_word[7:0];

  // register bytes with reserved positions at zero
  always_comb
  begin
    cfg_byte = 8'h00;
    cfg_byte[snf_pkg::CFG_OTP_PROT] = otp_prot;
    cfg_byte[snf_pkg::CFG_OTP_EN] = otp_en;
    cfg_byte[snf_pkg::CFG_FREEZE] = freeze;
    cfg_byte[snf_pkg::CFG_ECC_EN] = ecc_en;
    stat_byte = 8'h00;
    stat_byte[snf_pkg::ST_ECC_HI:snf_pkg::ST_ECC_LO] = ecc_res;
    stat_byte[snf_pkg::ST_PFAIL] = pfail;
    stat_byte[snf_pkg::ST_EFAIL] = efail;
    stat_byte[snf_pkg::ST_WEL] = write_enable_latch;
    stat_byte[snf_pkg::ST_BUSY] = (state != snf_pkg::ST_IDLE);
    drv_byte = 8'h00;
    drv_byte[snf_pkg::DRV_HI:snf_pkg::DRV_LO] = drv;
  end

  // next values of all fields but the otp lock, and the operation state
  always_comb
  begin
    next_otp_prot = otp_prot;
    next_otp_en = otp_en;
    next_freeze = freeze;
    next_ecc_en = ecc_en;
    next_ecc_res = ecc_res;
    next_pfail = pfail;
    next_efail = efail;
    next_wel = write_enable_latch;
    next_state = state;
    next_drv = drv;
    next_prog_go = 1'h0;
    next_erase_go = 1'h0;
    next_read_go = 1'h0;
    next_reset_go = 1'h0;
    // commands from the link
    if (cmd_valid)
    begin
      case (cmd_op)
        snf_pkg::OP_WR_EN: next_wel = 1'h1;
        snf_pkg::OP_WR_DIS: next_wel = 1'h0;
        snf_pkg::OP_SET:
        begin
          // status address falls to default: read-only fields untouched
          case (cmd_addr)
            snf_pkg::ADDR_CFG:
            begin
              // otp pair frozen once the area is locked
              if (!otp_locked)
              begin
                next_otp_prot = cmd_dat[snf_pkg::CFG_OTP_PROT];
                next_otp_en = cmd_dat[snf_pkg::CFG_OTP_EN];
              end
              next_ecc_en = cmd_dat[snf_pkg::CFG_ECC_EN];
              // freeze only rises with both guards set, then holds
              if (cmd_dat[snf_pkg::CFG_FREEZE] && guards_set_i)
              begin
                next_freeze = 1'h1;
              end
            end
            snf_pkg::ADDR_DRV: next_drv = cmd_dat[snf_pkg::DRV_HI:snf_pkg::DRV_LO];
            default: next_drv = drv;
          endcase
        end
        default: next_wel = write_enable_latch;
      endcase
    end
    // array requests; reset wins over the other requests, and over a completion in the same cycle for the state but not for its result bits
    if (reset_req_i)
    begin
      next_pfail = 1'h0;
      next_efail = 1'h0;
      next_ecc_res = snf_pkg::ECC_NONE;
      next_reset_go = 1'h1;
      next_state = snf_pkg::ST_RESET;
    end
    else if (state == snf_pkg::ST_IDLE)
    begin
      if (prog_req_i)
      begin
        next_pfail = 1'h0;
        if (write_enable_latch)
        begin
          if (target_locked_i || target_invalid_i)
          begin
            next_pfail = 1'h1;
          end
          else
          begin
            next_prog_go = 1'h1;
            next_state = snf_pkg::ST_PROG;
          end
        end
      end
      else if (erase_req_i)
      begin
        next_efail = 1'h0;
        if (write_enable_latch)
        begin
          if (target_locked_i)
          begin
            next_efail = 1'h1;
          end
          else
          begin
            next_erase_go = 1'h1;
            next_state = snf_pkg::ST_ERASE;
          end
        end
      end
      else if (read_req_i)
      begin
        next_ecc_res = snf_pkg::ECC_NONE;
        next_read_go = 1'h1;
        next_state = snf_pkg::ST_READ;
      end
    end
    // completion comes after the clears so a program or erase failure is never lost
    if (op_done_i && (state != snf_pkg::ST_IDLE))
    begin
      case (state)
        snf_pkg::ST_PROG: next_pfail = next_pfail | op_fail_i;
        snf_pkg::ST_ERASE: next_efail = next_efail | op_fail_i;
        snf_pkg::ST_READ:
        begin
          if (!op_fail_i)
          begin
            next_ecc_res = ecc_result_i;
          end
        end
        snf_pkg::ST_BOOT: next_ecc_res = ecc_result_i;
        default: next_ecc_res = next_ecc_res;
      endcase
      if (!reset_req_i)
      begin
        next_state = snf_pkg::ST_IDLE;
      end
    end
  end

  // otp lock is sticky once both bits are set
  assign next_otp_locked = otp_locked | (next_otp_prot & next_otp_en);

  // all fields registered; power-up starts with the boot read
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      otp_prot <= snf_pkg::CFG_RST[snf_pkg::CFG_OTP_PROT];
      otp_en <= snf_pkg::CFG_RST[snf_pkg::CFG_OTP_EN];
      freeze <= snf_pkg::CFG_RST[snf_pkg::CFG_FREEZE];
      ecc_en <= snf_pkg::CFG_RST[snf_pkg::CFG_ECC_EN];
      otp_locked <= 1'h0;
      ecc_res <= snf_pkg::STAT_RST[snf_pkg::ST_ECC_HI:snf_pkg::ST_ECC_LO];
      pfail <= snf_pkg::STAT_RST[snf_pkg::ST_PFAIL];
      efail <= snf_pkg::STAT_RST[snf_pkg::ST_EFAIL];
      write_enable_latch <= snf_pkg::STAT_RST[snf_pkg::ST_WEL];
      state <= snf_pkg::ST_BOOT;
      drv <= snf_pkg::DRV_RST[snf_pkg::DRV_HI:snf_pkg::DRV_LO];
      prog_go_o <= 1'h0;
      erase_go_o <= 1'h0;
      read_go_o <= 1'h0;
      reset_go_o <= 1'h0;
    end
    else
    begin
      otp_prot <= next_otp_prot;
      otp_en <= next_otp_en;
      freeze <= next_freeze;
      ecc_en <= next_ecc_en;
      otp_locked <= next_otp_locked;
      ecc_res <= next_ecc_res;
      pfail <= next_pfail;
      efail <= next_efail;
      write_enable_latch <= next_wel;
      state <= next_state;
      drv <= next_drv;
      prog_go_o <= next_prog_go;
      erase_go_o <= next_erase_go;
      read_go_o <= next_read_go;
      reset_go_o <= next_reset_go;
    end
  end

  // user-side views of the fields
  assign busy_o = (state != snf_pkg::ST_IDLE);
  assign ecc_enable_o = ecc_en;
  assign otp_access_o = otp_en;
  assign otp_writable_o = !otp_prot && otp_en && !otp_locked;
  assign otp_locked_o = otp_locked;
  assign prot_frozen_o = freeze;
  assign drive_quarters_o = 3'h4 - {1'h0, drv};

  // checks
  sequence s_prog_refused;
    (state == snf_pkg::ST_IDLE) && !reset_req_i && prog_req_i && write_enable_latch && target_locked_i;
  endsequence

  sequence s_erase_taken;
    (state == snf_pkg::ST_IDLE) && !reset_req_i && !prog_req_i && erase_req_i && write_enable_latch && !target_locked_i;
  endsequence

  a_wel_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_valid && (cmd_op == snf_pkg::OP_WR_EN) |=> write_enable_latch && stat_byte[snf_pkg::ST_WEL])
    else $error("write latch not set by enable");

  a_wel_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_valid && (cmd_op == snf_pkg::OP_WR_DIS) |=> !write_enable_latch)
    else $error("write latch not cleared by disable");

  a_prog_locked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_prog_refused |=> pfail && !prog_go_o && !busy_o)
    else $error("program to protected target not refused");

  a_erase_flow: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_erase_taken |=> !efail && erase_go_o && busy_o ##1 !erase_go_o)
    else $error("erase start wrong");

  a_erase_locked: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == snf_pkg::ST_IDLE) && !reset_req_i && !prog_req_i && erase_req_i && write_enable_latch && target_locked_i
    |=> efail && !erase_go_o)
    else $error("erase to locked target not flagged");

  a_reset_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    reset_req_i && !op_done_i |=> !pfail && !efail && (ecc_res == snf_pkg::ECC_NONE) && busy_o)
    else $error("reset did not clear status");

  a_read_ecc: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == snf_pkg::ST_READ) && op_done_i && !op_fail_i && !reset_req_i
    |=> (ecc_res == $past(ecc_result_i)) && !busy_o)
    else $error("ecc field not updated by read");

  a_ecc_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_valid && (cmd_op == snf_pkg::OP_SET) && (cmd_addr == snf_pkg::ADDR_CFG)
    |=> ecc_enable_o == $past(cmd_dat[snf_pkg::CFG_ECC_EN]))
    else $error("ecc enable not written");

  a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (cfg_byte[3:0] == 4'h0) && (stat_byte[7:6] == 2'h0) && (drv_byte[7] == 1'h0) && (drv_byte[4:0] == 5'h00))
    else $error("reserved bit reads nonzero");

  a_status_ro: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    cmd_valid && (cmd_op == snf_pkg::OP_SET) && (cmd_addr == snf_pkg::ADDR_STAT) && !reset_req_i
    && !prog_req_i && !erase_req_i && !read_req_i && !op_done_i |=> $stable(stat_byte))
    else $error("status changed by host write");

  a_drive_decode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (drv == 2'h0) |-> (drive_quarters_o == 3'h4))
    else $error("full strength not decoded");
endmodule

/* bench/snf_host_model.sv */
// host side link model: frames setting commands on the serial link
`timescale 1ns/1ps
module snf_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  // idle link: clock low, select high
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // free clock edges with the device deselected
  task automatic pulse(input int n);
    repeat (n)
    begin
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
  endtask
  // one frame msb first; bits past the 16th come back on miso while it is driven
  task automatic frame(input logic [23:0] w, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      mosi_o = w[23-i];
      #40 if (i >= 16) rd = {rd[6:0], miso_oe_i ? miso_i : 1'bx};
      sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    mosi_o = ~mosi_o; // released line shows no stale level
    #40 cs_n_o = 1'b1;
    #80;
  endtask
endmodule

/* bench/snf_feature_regs_test.sv */
// self-checking bench of the setting registers with a host model and a reference model
`timescale 1ns/1ps
module snf_feature_regs_test;
  logic ref_clk_i, srst_i, sclk, cs_n, mosi, miso, miso_oe;
  logic prog_req, erase_req, read_req, reset_req, locked, invalid, done, fail, guards;
  logic [1:0] ecc_in;
  logic prog_go, erase_go, read_go, reset_go, busy, ecc_en, otp_acc, otp_wr, otp_lk, frozen;
  logic [2:0] quarters;
  logic [7:0] rd;
  int n_fail, num_checks;
  int cfg, drv, ecc, pf, ef, write_enable_latch, lk; // reference model state
  // 200 MHz core clock
  always #2.5 ref_clk_i = ~ref_clk_i;
  snf_feature_regs i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .prog_req_i(prog_req), .erase_req_i(erase_req),
    .read_req_i(read_req), .reset_req_i(reset_req), .target_locked_i(locked), .target_invalid_i(invalid),
    .op_done_i(done), .op_fail_i(fail), .ecc_result_i(ecc_in), .guards_set_i(guards),
    .prog_go_o(prog_go), .erase_go_o(erase_go), .read_go_o(read_go), .reset_go_o(reset_go),
    .busy_o(busy), .ecc_enable_o(ecc_en), .otp_access_o(otp_acc), .otp_writable_o(otp_wr),
    .otp_locked_o(otp_lk), .prot_frozen_o(frozen), .drive_quarters_o(quarters));
  snf_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected status byte from the model
  function automatic logic [7:0] stat_exp(input logic b);
    return {2'b00, ecc[1:0], pf[0], ef[0], write_enable_latch[0], b};
  endfunction
  // read-setting frame and compare
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    i_host.frame({snf_pkg::OP_GET, a, 8'h55}, 24, rd);
    chk(rd, e);
  endtask
  // write-setting frame, model update, readback and port levels
  task automatic set(input logic [7:0] a, input logic [7:0] d);
    i_host.frame({snf_pkg::OP_SET, a, d}, 24, rd);
    if (a == snf_pkg::ADDR_CFG)
    begin
      if (lk == 0) cfg[7:6] = d[7:6];
      cfg[4] = d[4];
      if (guards && d[5]) cfg[5] = 1;
      if (cfg[7:6] == 3) lk = 1;
    end
    if (a == snf_pkg::ADDR_DRV) drv = d & 8'h60;
    if (a != 8'hA5) get(a, a == snf_pkg::ADDR_CFG ? cfg : a == snf_pkg::ADDR_DRV ? drv : stat_exp(0));
    chk(ecc_en, cfg[4]);
    chk(otp_acc, cfg[6]);
    chk(frozen, cfg[5]);
    chk(otp_lk, lk);
    chk(otp_wr, cfg[7:6] == 1 && lk == 0);
    chk(quarters, 4 - drv[6:5]);
  endtask
  // latch command: 06h sets, 04h clears
  task automatic cmd(input logic [7:0] op);
    i_host.frame({op, 16'h0000}, 8, rd);
    write_enable_latch = (op == snf_pkg::OP_WR_EN);
    get(snf_pkg::ADDR_STAT, stat_exp(0));
  endtask
  // array operation k: 0 program, 1 erase, 2 read, 3 reset
  task automatic op(input int k, input logic l, input logic v, input logic f, input logic [1:0] e);
    int go;
    go = (k >= 2) || (write_enable_latch && !l && !(k == 0 && v));
    if (k == 0 && go == 0) pf = write_enable_latch;
    if (k == 1 && go == 0) ef = write_enable_latch;
    @(negedge ref_clk_i);
    {prog_req, erase_req, read_req, reset_req} = 4'h8 >> k;
    locked = l;
    invalid = v;
    @(negedge ref_clk_i);
    {prog_req, erase_req, read_req, reset_req} = 4'h0;
    chk({prog_go, erase_go, read_go, reset_go}, go << (3 - k));
    chk(busy, go);
    if (go)
    begin
      if (k == 0) pf = 0;
      if (k == 1) ef = 0;
      if (k == 2) ecc = 0;
      if (k == 3) {pf, ef, ecc} = 0;
      get(snf_pkg::ADDR_STAT, stat_exp(1));
      @(negedge ref_clk_i);
      {done, fail, ecc_in} = {1'b1, f, e};
      @(negedge ref_clk_i);
      done = 1'b0;
      if (k == 0) pf = f;
      if (k == 1) ef = f;
      if (k == 2 && !f) ecc = e;
      chk(busy, 1'b0);
    end
    get(snf_pkg::ADDR_STAT, stat_exp(0));
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    #300000;
    n_fail++;
    conclude();
  end
  // main sequence
  initial
  begin
    {ref_clk_i, srst_i, prog_req, erase_req, read_req, reset_req} = 6'h01 << 4;
    {locked, invalid, done, fail, guards, ecc_in} = 6'h00;
    {n_fail, num_checks, drv, ecc, pf, ef, write_enable_latch, lk} = 0;
    cfg = 8'h10;
    drv = 8'h20;
    void'($urandom(13776));
    i_host.pulse(4);
    repeat (8) @(negedge ref_clk_i);
    srst_i = 1'b0;
    i_host.pulse(4);
    chk(busy, 1'b1);
    get(snf_pkg::ADDR_STAT, 8'h01);
    @(negedge ref_clk_i);
    {done, ecc_in} = 3'h5;
    @(negedge ref_clk_i);
    done = 1'b0;
    ecc = 1;
    get(snf_pkg::ADDR_STAT, stat_exp(0));
    get(snf_pkg::ADDR_CFG, 8'h10);
    get(snf_pkg::ADDR_DRV, 8'h20);
    set(snf_pkg::ADDR_CFG, 8'h4F);
    set(snf_pkg::ADDR_CFG, 8'h3F);
    @(negedge ref_clk_i) guards = 1'b1;
    set(snf_pkg::ADDR_CFG, 8'h20);
    set(snf_pkg::ADDR_CFG, 8'hC0);
    set(snf_pkg::ADDR_CFG, 8'h50);
    for (int c = 0; c < 4; c++) set(snf_pkg::ADDR_DRV, ($urandom & 8'h9F) | (c << 5));
    set(snf_pkg::ADDR_STAT, 8'hFF);
    set(8'hA5, $urandom);
    get(snf_pkg::ADDR_CFG, cfg);
    // status reads below run with internal ecc on
    op(0, 0, 0, 0, 2'h0);
    cmd(snf_pkg::OP_WR_EN);
    op(0, 0, 0, 1, 2'h0);
    op(1, 1, 0, 0, 2'h0);
    op(0, 0, 1, 0, 2'h0);
    op(1, 0, 0, 0, 2'h0);
    op(0, 0, 0, 0, 2'h0);
    op(1, 0, 0, 1, 2'h0);
    op(3, 0, 0, 0, 2'h0);
    op(2, 0, 0, 0, 2'h2);
    op(2, 0, 0, 0, 2'h1);
    op(2, 0, 0, 1, 2'h2);
    cmd(snf_pkg::OP_WR_DIS);
    op(1, 0, 0, 0, 2'h0);
    conclude();
  end
endmodule
